// ---- design/burst_cfg.svh ----
`ifndef BURST_CFG_SVH
`define BURST_CFG_SVH

// Register byte addresses
`define A_CTRL 8'h00
`define A_SYNC 8'h04
`define A_STAT 8'h08
`define LEN_PAGE 3'h1
`define LEN_IDX 4:2
`define LEN_TOP 7:5
`define WORD_LSB 1:0

// Control word fields
`define CTRL_SRC 2:0
`define CTRL_DIV 15:8
`define CTRL_LEAD 23:16
`define CTRL_AUX 25:24
`define CTRL_AUXEN 26
`define CTRL_INV 27

// Sync word fields
`define SYNC_MASK 7:0
`define SYNC_EN 15:8
`define SYNC_OUTEN 23:16

// Status word fields
`define ST_RUN 0
`define ST_CH 3:1
`define ST_PCNT 31:8

// Source selector codes
`define SRC_EXT_RISE 3'h0
`define SRC_EXT_FALL 3'h1
`define SRC_OSC_80 3'h2
`define SRC_OSC_64 3'h3
`define SRC_OSC_50 3'h4

// Reset values and the pulse index saturation limit
`define RST_SRC 3'h2
`define RST_DIV 8'h01
`define RST_BYTE 8'h00
`define RST_LEN 24'h000000
`define RST_ENABLES 8'hff
`define MASK_SAT 8'hff

`endif

// ---- design/burst_pkg.sv ----
package burst_pkg;
  typedef enum logic [1:0] {aux_free, aux_high, aux_low} aux_mode_t;
  typedef enum logic {st_idle, st_play} seq_state_t;
endpackage : burst_pkg

// ---- design/div_if.sv ----
`timescale 1ns/1ps
interface div_if;
  logic [2:0] src_sel;
  logic [7:0] divider;
  logic [7:0] lead;
  logic main_tick;
  logic sync_tick;
  logic is_ext;
  modport div (input src_sel, input divider, input lead,
               output main_tick, output sync_tick, output is_ext);
  modport user (output src_sel, output divider, output lead,
                input main_tick, input sync_tick, input is_ext);
endinterface : div_if

// ---- design/base_divider.sv ----
`timescale 1ns/1ps
`include "burst_cfg.svh"
module base_divider
  import burst_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Source pins
  input wire logic osc_80,
  input wire logic osc_64,
  input wire logic osc_50,
  input wire logic ext_trig,
  // Ticks to the sequencer
  div_if.div dv
);
  logic [3:0] prev;
  logic [7:0] cnt;
  logic main_q;
  logic sync_q;
  logic src_tick;

  wire [3:0] now = {ext_trig, osc_50, osc_64, osc_80};
  wire [3:0] rise = now & ~prev;
  wire ext_fall = prev[3] & ~ext_trig;
  wire ext_sel = (dv.src_sel == `SRC_EXT_RISE) || (dv.src_sel == `SRC_EXT_FALL);
  // A zero factor would never wrap, so it behaves as one
  wire [7:0] eff_div = (dv.divider == `RST_BYTE) ? `RST_DIV : dv.divider;
  wire [7:0] top_cnt = eff_div - `RST_DIV;
  // Lead is meaningless against an external edge train of unknown rate
  wire [7:0] eff_lead = ext_sel ? `RST_BYTE : ((dv.lead > top_cnt) ? top_cnt : dv.lead);
  wire [7:0] sync_cnt = top_cnt - eff_lead;

  always_comb begin
    case (dv.src_sel)
      `SRC_EXT_RISE: src_tick = rise[3];
      `SRC_EXT_FALL: src_tick = ext_fall;
      `SRC_OSC_80: src_tick = rise[0];
      `SRC_OSC_64: src_tick = rise[1];
      `SRC_OSC_50: src_tick = rise[2];
      default: src_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      prev <= 4'h0;
      cnt <= `RST_BYTE;
      main_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      prev <= now;
      main_q <= src_tick && (cnt >= top_cnt);
      // A shrunk divider can leave the count above its top: sync then rides with main
      sync_q <= src_tick && ((cnt == sync_cnt) || (cnt > top_cnt));
      if (src_tick) begin
        cnt <= (cnt >= top_cnt) ? `RST_BYTE : 8'(cnt + `RST_DIV);
      end
    end
  end

  assign dv.main_tick = main_q;
  assign dv.sync_tick = sync_q;
  assign dv.is_ext = ext_sel;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  main_from_src_a: assert property (main_q |-> $past(src_tick))
    else $error("main tick without a source edge");
  div_one_a: assert property ((eff_div == `RST_DIV) && src_tick |=> main_q)
    else $error("divide by one missed a source edge");
  ext_no_lead_a: assert property ($past(ext_sel) && main_q |-> sync_q)
    else $error("sync leads main tick on external source");
  lead_internal_a: assert property (sync_q && !main_q |-> !$past(ext_sel))
    else $error("sync lead seen with external source");
endmodule : base_divider

// ---- design/sync_shaper.sv ----
`timescale 1ns/1ps
`include "burst_cfg.svh"
module sync_shaper
  import burst_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Timing and state
  input wire logic sync_tick,
  input wire logic active,
  input wire logic ch_sync_en,
  input wire logic [7:0] pulse_idx,
  // Mask setup
  input wire logic [7:0] mask_cnt,
  input wire logic invert,
  // Output
  output logic sync_pulse
);
  // Plain mask drops the first pulses; inverted mask keeps only them
  wire pass = invert ? (pulse_idx < mask_cnt) : (pulse_idx >= mask_cnt);
  wire fire = sync_tick && active && ch_sync_en && pass;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sync_pulse <= 1'b0;
    end else begin
      sync_pulse <= fire;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  mask_front_a: assert property (sync_pulse && !$past(invert) |->
    $past(pulse_idx) >= $past(mask_cnt))
    else $error("masked sync pulse escaped");
  mask_inverted_a: assert property (sync_pulse && $past(invert) |->
    $past(pulse_idx) < $past(mask_cnt))
    else $error("inverted mask passed a late pulse");
  sync_enable_a: assert property (!ch_sync_en |=> !sync_pulse)
    else $error("sync pulse from a sync-disabled channel");
endmodule : sync_shaper

// ---- design/burst_pulse_sequencer.sv ----
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "burst_cfg.svh"
// Notes on behaviour
// - Main clock comes from one of three oscillators or chosen external trigger edges.
// - Divider factor 1 to 255 divides the selected source.
// - Each channel holds a burst length of 1 to 16777215 pulses.
// - Per-channel bit lets sync pulses out during that channel's burst.
// - Disabled channel outputs stay quiet but still count their pulses.
// - Sync leads its output pulse by 0 to divider-1 source periods.
// - No sync lead while running from the external trigger.
// - First mask-count sync pulses of each burst are suppressed; outputs untouched.
// - Inverted mask passes only the first mask-count sync pulses of a burst.
// - Auxiliary mode: free running, run on input high, or on input low.
// - An unmet running condition keeps the sequencer idle with no bursts.
// - Auxiliary output pulses at each sequence end when enabled.
module burst_pulse_sequencer
  import burst_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources
  input wire logic osc_80,
  input wire logic osc_64,
  input wire logic osc_50,
  input wire logic ext_trig,
  // Auxiliary pins
  input wire logic aux_in,
  output logic aux_out,
  // Laser channel and sync outputs
  output logic [7:0] ch_out,
  output logic sync_out
);
  logic [2:0] src_sel;
  logic [7:0] divider;
  logic [7:0] lead;
  aux_mode_t aux_mode;
  logic aux_en;
  logic invert;
  logic [7:0] mask_cnt;
  logic [7:0] sync_en;
  logic [7:0] out_en;
  logic [23:0] len [8];
  logic [7:0] nz;
  seq_state_t state;
  logic [2:0] cur_ch;
  logic [23:0] pcnt;

  div_if dif ();
  assign dif.src_sel = src_sel;
  assign dif.divider = divider;
  assign dif.lead = lead;

  base_divider u_div (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .osc_80(osc_80),
    .osc_64(osc_64),
    .osc_50(osc_50),
    .ext_trig(ext_trig),
    .dv(dif)
  );

  // Next non-empty channel after 'from', top bit set when the scan wrapped
  function automatic logic [3:0] next_ch(input logic [2:0] from, input logic [7:0] mask);
    logic [3:0] r;
    logic [2:0] j;
    r = {1'b1, from};
    for (int k = 7; k >= 1; k--) begin
      j = from + 3'(k);
      if (mask[j]) begin
        r = {(j <= from), j};
      end
    end
    return r;
  endfunction : next_ch

  // Bus decode
  wire setup = psel && !penable;
  wire wr = psel && penable && pready && pwrite;
  wire sel_ctrl = (paddr == `A_CTRL);
  wire sel_sync = (paddr == `A_SYNC);
  wire sel_stat = (paddr == `A_STAT);
  wire sel_len = (paddr[`LEN_TOP] == `LEN_PAGE) && (paddr[`WORD_LSB] == 2'h0);
  wire [2:0] len_idx = paddr[`LEN_IDX];
  wire mapped = sel_ctrl || sel_sync || sel_stat || sel_len;
  wire [31:0] ctrl_word = {4'h0, invert, aux_en, aux_mode, lead, divider, 5'h00, src_sel};
  wire [31:0] sync_word = {8'h00, out_en, sync_en, mask_cnt};
  wire [31:0] stat_word = {pcnt, 4'h0, cur_ch, state == st_play};
  wire [31:0] rd_word = sel_ctrl ? ctrl_word :
                        sel_sync ? sync_word :
                        sel_stat ? stat_word :
                        sel_len ? {8'h00, len[len_idx]} : 32'h0000_0000;

  // Sequencer decode
  wire any_len = |nz;
  wire run_ok = (aux_mode == aux_free) || ((aux_mode == aux_high) && aux_in) ||
                ((aux_mode == aux_low) && !aux_in);
  wire [3:0] first = next_ch(3'h7, nz);
  wire [3:0] nxt = next_ch(cur_ch, nz);
  wire last = ({1'b0, pcnt} + 25'h000_0001) >= {1'b0, len[cur_ch]};
  wire active = (state == st_play) && run_ok && any_len;
  wire fire = active && dif.main_tick;
  wire [7:0] pulse_idx = (pcnt > 24'(`MASK_SAT)) ? `MASK_SAT : pcnt[7:0];
  wire [7:0] cur_bit = 8'h01 << cur_ch;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_len
      assign nz[g] = |len[g];
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          len[g] <= `RST_LEN;
        end else if (wr && sel_len && (len_idx == 3'(g))) begin
          len[g] <= pwdata[23:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= setup ? rd_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      src_sel <= `RST_SRC;
      divider <= `RST_DIV;
      lead <= `RST_BYTE;
      aux_mode <= aux_free;
      aux_en <= 1'b0;
      invert <= 1'b0;
    end else if (wr && sel_ctrl) begin
      src_sel <= pwdata[`CTRL_SRC];
      divider <= pwdata[`CTRL_DIV];
      lead <= pwdata[`CTRL_LEAD];
      aux_mode <= aux_mode_t'(pwdata[`CTRL_AUX]);
      aux_en <= pwdata[`CTRL_AUXEN];
      invert <= pwdata[`CTRL_INV];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mask_cnt <= `RST_BYTE;
      sync_en <= `RST_ENABLES;
      out_en <= `RST_ENABLES;
    end else if (wr && sel_sync) begin
      mask_cnt <= pwdata[`SYNC_MASK];
      sync_en <= pwdata[`SYNC_EN];
      out_en <= pwdata[`SYNC_OUTEN];
    end
  end

  // Leaving the running condition restarts the sequence from its first burst
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= st_idle;
      cur_ch <= 3'h0;
      pcnt <= `RST_LEN;
    end else begin
      case (state)
        st_idle: begin
          if (run_ok && any_len) begin
            state <= st_play;
            cur_ch <= first[2:0];
            pcnt <= `RST_LEN;
          end
        end
        st_play: begin
          if (!run_ok || !any_len) begin
            state <= st_idle;
          end else if (dif.main_tick) begin
            if (last) begin
              cur_ch <= nxt[2:0];
              pcnt <= `RST_LEN;
            end else begin
              pcnt <= 24'(pcnt + 24'h00_0001);
            end
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ch_out <= 8'h00;
      aux_out <= 1'b0;
    end else begin
      ch_out <= fire ? (out_en & cur_bit) : 8'h00;
      aux_out <= fire && last && nxt[3] && aux_en;
    end
  end

  sync_shaper u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .sync_tick(dif.sync_tick),
    .active(active),
    .ch_sync_en(sync_en[cur_ch]),
    .pulse_idx(pulse_idx),
    .mask_cnt(mask_cnt),
    .invert(invert),
    .sync_pulse(sync_out)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence burst_end_s;
    fire && last;
  endsequence

  sequence burst_step_s;
    fire && !last;
  endsequence

  sequence seq_start_s;
    (state == st_idle) && run_ok && any_len;
  endsequence

  sequence seq_wrap_s;
    nxt[3] && aux_en;
  endsequence

  out_gated_a: assert property (|ch_out |-> (ch_out & ~$past(out_en)) == 8'h00)
    else $error("disabled channel produced a pulse");
  one_channel_a: assert property ($onehot0(ch_out))
    else $error("more than one channel pulsed");
  idle_quiet_a: assert property (!run_ok |=> ch_out == 8'h00 && state == st_idle)
    else $error("output while running condition unmet");
  aux_gate_a: assert property (aux_out |-> $past(aux_en) && $past(last))
    else $error("aux pulse without enable or sequence end");
  burst_order_a: assert property ((burst_end_s and run_ok) |=> cur_ch == $past(nxt[2:0]))
    else $error("wrong next burst channel");
  burst_restart_a: assert property (burst_end_s |=> pcnt == 24'h00_0000)
    else $error("pulse count not cleared at burst end");
  count_step_a: assert property (burst_step_s |=> pcnt == $past(pcnt) + 24'h00_0001)
    else $error("pulse count did not advance");
  seq_start_a: assert property (seq_start_s |=>
    (state == st_play) && (cur_ch == $past(first[2:0])))
    else $error("sequence did not start at first burst");
  seq_wrap_a: assert property ((burst_end_s and seq_wrap_s) |=> aux_out)
    else $error("missing aux pulse at sequence end");
  aux_off_a: assert property (!aux_en |=> !aux_out)
    else $error("aux pulse while disabled");
  pulse_out_a: assert property (fire |=> ch_out == ($past(out_en) & $past(cur_bit)))
    else $error("channel pulse missing or misplaced");
  tick_needed_a: assert property (|ch_out |-> $past(dif.main_tick))
    else $error("channel pulse without main tick");
  sync_needed_a: assert property (sync_out |-> $past(dif.sync_tick))
    else $error("sync pulse without sync tick");
  idle_sync_a: assert property (!active |=> !sync_out)
    else $error("sync pulse while sequencer inactive");
  idle_aux_a: assert property (state == st_idle |=> !aux_out)
    else $error("aux pulse while idle");
  ext_lead_a: assert property (dif.sync_tick && $past(dif.is_ext) |-> dif.main_tick)
    else $error("sync tick ahead of main tick on trigger source");

  // Bus answer: one wait-free access cycle, quiet outside it
  apb_ready_a: assert property (setup |=> pready)
    else $error("no ready after setup");
  apb_quiet_a: assert property (!pready |-> (prdata == 32'h0000_0000) && !pslverr)
    else $error("bus outputs not quiet outside access");
  apb_err_a: assert property (pslverr |-> pready && !$past(mapped))
    else $error("error on a mapped address");
  hold_count_a: assert property (active && !dif.main_tick |=> $stable(pcnt) || !active)
    else $error("pulse count moved without a main tick");
  aux_mode_a: assert property ((aux_mode == aux_high) && !aux_in |=> state == st_idle)
    else $error("sequencer ran with aux input low in high mode");
endmodule : burst_pulse_sequencer

// ---- testbench/laser_far_end.sv ----
`timescale 1ns/1ps
module laser_far_end (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Sources towards the sequencer
  output logic osc_80,
  output logic osc_64,
  output logic osc_50,
  output logic ext_trig,
  // Sequencer outputs and count clear
  input wire logic [7:0] ch_out,
  input wire logic sync_out,
  input wire logic aux_out,
  input wire logic clr,
  // Measurements
  output int ch_cnt [8],
  output int sync_cnt,
  output logic seq_done,
  output int tot,
  output int aux_tot,
  output int gap
);
  int run_ch [8];
  int run_sync;
  int since;
  // Free-running sources, offset so no edge lands on a sampling edge
  initial begin
    osc_80 = 0;
    osc_64 = 0;
    osc_50 = 0;
    ext_trig = 0;
    #0.7;
    fork
      forever #6.25 osc_80 = ~osc_80;
      forever #7.8125 osc_64 = ~osc_64;
      forever #10 osc_50 = ~osc_50;
      forever #20 ext_trig = ~ext_trig;
    join
  end
  // Per-sequence counts close on the end-of-sequence marker, its own edge included
  always @(posedge clk_sys) begin
    seq_done <= aux_out;
    if (!rst_b || clr) begin
      tot <= 0;
      aux_tot <= 0;
    end else begin
      tot <= tot + $countones(ch_out);
      aux_tot <= aux_tot + int'(aux_out);
    end
    since <= sync_out ? 1 : since + 1;
    if (|ch_out) gap <= sync_out ? 0 : since;
    for (int i = 0; i < 8; i++) begin
      run_ch[i] <= aux_out ? 0 : run_ch[i] + int'(ch_out[i]);
      if (aux_out) ch_cnt[i] <= run_ch[i] + int'(ch_out[i]);
    end
    run_sync <= aux_out ? 0 : run_sync + int'(sync_out);
    if (aux_out) begin
      sync_cnt <= run_sync + int'(sync_out);
    end
  end
endmodule : laser_far_end

// ---- testbench/burst_pulse_sequencer_tb.sv ----
`timescale 1ns/1ps
`include "burst_cfg.svh"
module burst_pulse_sequencer_tb;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} rd_note_t;
  typedef struct {int c [8]; int s;} seq_note_t;
  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, aux_in, aux_out, sync_out, clr;
  logic osc_80, osc_64, osc_50, ext_trig, seq_done;
  logic [7:0] paddr, en, oe, ch_out;
  logic [31:0] pwdata, prdata;
  int ch_cnt [8];
  int sync_cnt, tot, aux_tot, gap, err_count, compares, k, mk, seed;
  int lens [8];
  seq_note_t n;
  rd_note_t rq [$];
  seq_note_t sq [$];
  logic [1:0] mode_tab [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  logic [4:0] ain_tab = 5'b01001;
  logic [4:0] run_tab = 5'b00101;
  logic [2:0] src_tab [5] = '{`SRC_EXT_RISE, `SRC_EXT_FALL, `SRC_OSC_80, `SRC_OSC_64, `SRC_OSC_50};
  real per_tab [5] = '{40.0, 40.0, 12.5, 15.625, 20.0};
  int lead_tab [4] = '{0, 2, 3, 7};
  burst_pulse_sequencer u_burst_pulse_sequencer (.clk_sys(clk_sys), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_80(osc_80), .osc_64(osc_64),
    .osc_50(osc_50), .ext_trig(ext_trig), .aux_in(aux_in), .aux_out(aux_out),
    .ch_out(ch_out), .sync_out(sync_out));
  laser_far_end u_laser_far_end (.clk_sys(clk_sys), .rst_b(rst_b), .osc_80(osc_80),
    .osc_64(osc_64), .osc_50(osc_50), .ext_trig(ext_trig), .ch_out(ch_out),
    .sync_out(sync_out), .aux_out(aux_out), .clr(clr), .ch_cnt(ch_cnt), .sync_cnt(sync_cnt),
    .seq_done(seq_done), .tot(tot), .aux_tot(aux_tot), .gap(gap));
  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  task fail(input string s);
    $display("FAIL %0t %s", $time, s);
    err_count++;
  endtask : fail
  task chk_val(input int got, input int exp, input int tol, input string s);
    compares++;
    if (got > exp + tol || got < exp - tol) fail(s);
  endtask : chk_val
  task chk_rd(input rd_note_t r);
    compares++;
    if ((prdata & r.m) !== (r.d & r.m) || pslverr !== r.e) fail("register access");
  endtask : chk_rd
  task chk_seq(input seq_note_t s);
    for (int i = 0; i < 8; i++) chk_val(ch_cnt[i], s.c[i], 0, "channel count");
    chk_val(sync_cnt, s.s, 0, "sync count");
  endtask : chk_seq
  // Results are judged as they appear, against the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1) chk_rd(rq.pop_front());
    if (seq_done === 1'b1 && sq.size() > 0) chk_seq(sq.pop_front());
  end
  task cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask : cyc
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
    input logic e);
    rq.push_back('{d, m, e});
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 0;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask : apb
  task cfg(input logic [2:0] s, input logic [7:0] d, input logic [7:0] l, input logic [1:0] a,
    input logic ae, input logic iv);
    apb(1, `A_CTRL, {4'h0, iv, ae, a, l, d, 5'h00, s}, 0, 0);
  endtask : cfg
  task wait_seq;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (seq_done !== 1'b1 && k < 5000);
    if (k >= 5000) fail("no sequence end");
    cyc(1);
  endtask : wait_seq
  task measure(input int c);
    clr <= 1;
    cyc(1);
    clr <= 0;
    cyc(c);
  endtask : measure
  task final_report;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    #120000;
    fail("timeout");
    final_report();
  end
  initial begin
    seed = 23529;
    {rst_b, psel, penable, pwrite, aux_in, clr} = 0;
    paddr = 0;
    pwdata = 0;
    cyc(10);
    rst_b <= 1;
    apb(0, `A_CTRL, 32'h00000102, 32'hffffffff, 0);
    apb(0, `A_SYNC, 32'h00ffff00, 32'hffffffff, 0);
    apb(0, 8'h20, 32'h00000000, 32'hffffffff, 0);
    apb(0, `A_STAT, 32'h00000000, 32'h00000001, 0);
    apb(1, 8'h10, 32'h00000005, 0, 1);
    apb(0, 8'h10, 32'h00000000, 32'hffffffff, 1);
    apb(1, 8'h3c, 32'hffffffff, 0, 0);
    apb(0, 8'h3c, 32'h00ffffff, 32'h00ffffff, 0);
    $display("test registers done");
    for (int it = 0; it < 4; it++) begin
      en = 8'($random(seed));
      oe = 8'($random(seed));
      mk = $unsigned($random(seed)) % 4;
      n.s = 0;
      for (int i = 0; i < 8; i++) begin
        lens[i] = (i == it) ? 4 : $unsigned($random(seed)) % 4;
        apb(1, 8'h20 + 8'(4 * i), 32'(lens[i]), 0, 0);
        n.c[i] = oe[i] ? lens[i] : 0;
        if (en[i] && it[0]) n.s += lens[i] < mk ? lens[i] : mk;
        if (en[i] && !it[0]) n.s += lens[i] > mk ? lens[i] - mk : 0;
      end
      apb(1, `A_SYNC, {8'h00, oe, en, 8'(mk)}, 0, 0);
      cfg(`SRC_OSC_80, 8'h01, 8'h00, 2'h0, 1, it[0]);
      wait_seq();
      sq.push_back(n);
      wait_seq();
    end
    $display("test sequences done");
    apb(1, `A_SYNC, 32'h00ffff00, 0, 0);
    cfg(`SRC_OSC_80, 8'h01, 8'h00, 2'h0, 0, 0);
    measure(400);
    chk_val(aux_tot, 0, 0, "aux pulse while disabled");
    chk_val(int'(tot > 0), 1, 0, "no pulses");
    $display("test aux out done");
    for (int j = 0; j < 5; j++) begin
      aux_in <= ain_tab[j];
      cfg(`SRC_OSC_80, 8'h01, 8'h00, mode_tab[j], 0, 0);
      cyc(20);
      measure(300);
      chk_val(int'(tot > 0), int'(run_tab[j]), 0, "aux gate");
    end
    $display("test aux modes done");
    for (int i = 0; i < 8; i++) apb(1, 8'h20 + 8'(4 * i), i == 0 ? 32'd1000 : 32'd0, 0, 0);
    apb(1, `A_SYNC, 32'h00ffff00, 0, 0);
    for (int j = 0; j < 5; j++) begin
      mk = 1 + $unsigned($random(seed)) % 6;
      cfg(src_tab[j], 8'(mk), 8'h00, 2'h0, 0, 0);
      cyc(50);
      measure(1000);
      chk_val(tot, int'(4000.0 / (per_tab[j] * mk)), 2, "main clock rate");
    end
    $display("test rates done");
    for (int j = 0; j < 4; j++) begin
      cfg(`SRC_OSC_50, 8'h04, 8'(lead_tab[j]), 2'h0, 0, 0);
      cyc(100);
      chk_val(gap, 5 * (lead_tab[j] < 3 ? lead_tab[j] : 3), 0, "sync lead");
    end
    cfg(`SRC_EXT_RISE, 8'h04, 8'h02, 2'h0, 0, 0);
    cyc(100);
    chk_val(gap, 0, 0, "lead on trigger");
    $display("test lead done");
    final_report();
  end
endmodule : burst_pulse_sequencer_tb
